// ===== shared/tec_regs.svh
// Register offsets, field positions and reset values of the timer control slice
`ifndef TEC_REGS_SVH
`define TEC_REGS_SVH
`define TEC_OFF_BV_CLEAR   8'h06
`define TEC_OFF_BV_SET     8'h07
`define TEC_OFF_EVENT_CONTROL     8'h09
`define TEC_OFF_INT_EN     8'h0a
`define TEC_OFF_INT_FLAGS  8'h0b
`define TEC_OFF_CTRL       8'h0c
`define TEC_OFF_BUF_WRITE  8'h0d
`define TEC_BV_PERIOD      0
`define TEC_BV_CHAN0       1
`define TEC_BV_CHAN1       2
`define TEC_BV_CHAN2       3
`define TEC_EV_A_EN        0
`define TEC_EV_A_ACT_LSB   1
`define TEC_EV_B_EN        4
`define TEC_EV_B_ACT_LSB   5
`define TEC_INT_WRAP       0
`define TEC_INT_CHAN0      4
`define TEC_CTRL_MODE_LSB  0
`define TEC_CTRL_LOCK      3
`define TEC_CTRL_FORCE     4
`define TEC_RST_BYTE       8'h00
`define TEC_RST_PERIOD     16'hffff
`define TEC_RST_COMPARE    16'h0000
`endif

// ===== shared/tec_pkg.sv
// Types shared by the timer control slice
package tec_pkg;
  typedef enum logic [2:0]
  {
    TEC_EVA_RISE   = 3'h0,
    TEC_EVA_TOGGLE = 3'h1,
    TEC_EVA_HIGH   = 3'h2,
    TEC_EVA_DIRECTION_BY_EVENT = 3'h3
  } tec_eva_t;
  typedef enum logic [2:0]
  {
    TEC_EVB_NONE    = 3'h0,
    TEC_EVB_DIRECTION_BY_EVENT  = 3'h3,
    TEC_EVB_RST_RISE = 3'h4,
    TEC_EVB_RST_TOG  = 3'h5,
    TEC_EVB_RST_HIGH = 3'h6
  } tec_evb_t;
  typedef enum logic [2:0]
  {
    TEC_WG_NORMAL = 3'h0,
    TEC_WG_FREQ   = 3'h1,
    TEC_WG_SINGLE = 3'h3,
    TEC_WG_DSTOP  = 3'h5,
    TEC_WG_DSBOTH = 3'h6,
    TEC_WG_DSBOT  = 3'h7
  } tec_wg_t;
endpackage

// ===== rtl/tec_buffers.sv
// Period and compare buffers with their working copies, read out through a register
`include "tec_regs.svh"
module tec_buffers #(
  parameter int W = 16
) (
  input  wire logic         clk,        // Core clock
  input  wire logic         rst_n,      // Synchronous reset, active low
  input  wire logic         ce,         // Clock enable
  input  wire logic [1:0]   wr_sel,     // 0 period, 1..3 channel 0..2
  input  wire logic         wr_en,      // Buffer write strobe
  input  wire logic [W-1:0] wr_data,    // Buffer write value
  input  wire logic         transfer,   // Copy buffers into working registers
  input  wire logic [1:0]   rd_sel,     // Working register to read out
  output logic      [W-1:0] rd_data     // Registered working value
);
  logic [W-1:0] buf_q [4];
  logic [W-1:0] work_q [4];
  logic [W-1:0] rd_q;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 4; i++)
      begin
        buf_q[i]  <= (i == 0) ? `TEC_RST_PERIOD : `TEC_RST_COMPARE;
        work_q[i] <= (i == 0) ? `TEC_RST_PERIOD : `TEC_RST_COMPARE;
      end
      rd_q <= '0;
    end
    else if (ce)
    begin
      if (wr_en)
        buf_q[wr_sel] <= wr_data;
      if (transfer)
        for (int i = 0; i < 4; i++)
          work_q[i] <= buf_q[i];
      rd_q <= work_q[rd_sel];
    end
  end
  assign rd_data = rd_q;
endmodule

// ===== rtl/tec_core.sv
// Timer control slice: buffer-valid flags, event inputs, interrupt enables and flags
`include "tec_regs.svh"

// Summary of operation
// [R1] Compare buffer write sets that channel's valid bit; update clears it.
// [R2] Period buffer write sets period valid bit; update clears it.
// [R3] Valid bits: 3 chan2, 2 chan1, 1 chan0, 0 period.
// [R4] Writing ones to set alias at 0x07 sets valid bits; zeros ignored.
// [R5] Event control: B action 7:5, B enable 4, A action 3:1, A enable 0.
// [R6] A action 0 counts rises, 1 any edge, 2 clocks while high.
// [R7] A action 3 counts clocks; event gives direction, latched at count.
// [R8] B action 3 gives direction from event B, counting follows event A.
// [R9] B action 4 restart on rise, 5 any edge, 6 hold restart while high.
// [R10] Event B ignored while its enable bit is zero.
// [R11] Event A ignored while its enable bit is zero.
// [R12] Interrupt enables at 0x0A: bits 6,5,4 channels, bit 0 wrap.
// [R13] Channel flag sets when count equals that channel's compare value.
// [R14] Channel flags clear only by writing one at 0x0B.
// [R15] Wrap flag sets at mode's top or bottom; write one clears.
// [R16] Channel flags in bits 6,5,4 of flag register, reset zero.
// [R17] Writing ones to clear alias at 0x06 clears valid bits.
// [R18] Update copies buffers unless locked; forced update ignores lock.
// [R19] Waveform mode picks update and wrap conditions.
// [R20] Interrupt request while any flag and its enable are both set.
module tec_core
  import tec_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         CORE_CLK,     // 200 MHz core clock
  input  wire logic         RESET_N,      // Synchronous reset, active low
  input  wire logic         CLK_EN,       // Freezes all state while low
  input  wire logic [7:0]   REG_ADDR,     // Register address
  input  wire logic [W-1:0] REG_WDATA,    // Write data, low byte for 8-bit registers
  input  wire logic         REG_WR,       // Write strobe
  input  wire logic         REG_RD,       // Read strobe
  output logic      [W-1:0] REG_RDATA,    // Read data, cycle after strobe
  input  wire logic         PRESCALE_TICK,// Prescaled clock tick
  input  wire logic         EVENT_A,      // Event input A
  input  wire logic         EVENT_B,      // Event input B
  output logic      [W-1:0] COUNT_VALUE,  // Counter value
  output logic              COUNT_DOWN,   // Current direction, 1 down
  output logic              IRQ           // Interrupt request
);
  import tec_pkg::*;

  logic [3:0]   bv_q, bv_d;
  logic [7:0]   event_control_q, event_control_d;
  logic [7:0]   inten_q, inten_d;
  logic [7:0]   flags_q, flags_d;
  logic [2:0]   mode_q, mode_d;
  logic         lock_q, lock_d;
  logic [W-1:0] cnt_q, cnt_d;
  logic         dir_q, dir_d;
  logic         evb_rst_q, evb_rst_d;
  logic         eva_prev_q, evb_prev_q;
  logic [W-1:0] rdata_q, rdata_d;
  logic         irq_q;
  logic [W-1:0] cmp_q [3];
  logic [W-1:0] per_q;
  logic [1:0]   scan_q;
  logic [W-1:0] scan_data;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  logic wr_buf, upd_evt, force_upd, transfer, cnt_step, at_top, at_bot;
  logic wrap_evt;
  logic [2:0] cmp_hit;
  tec_eva_t eva;
  tec_evb_t evb;

  assign eva = tec_eva_t'(event_control_q[`TEC_EV_A_ACT_LSB +: 3]);
  assign evb = tec_evb_t'(event_control_q[`TEC_EV_B_ACT_LSB +: 3]);
  assign wr_buf = REG_WR && hit(REG_ADDR, `TEC_OFF_BUF_WRITE);
  assign force_upd = REG_WR && hit(REG_ADDR, `TEC_OFF_CTRL) && REG_WDATA[`TEC_CTRL_FORCE];
  assign at_top = (cnt_q == ((mode_q == TEC_WG_FREQ) ? cmp_q[0] : per_q));
  assign at_bot = (cnt_q == '0);

  // Counting source and direction
  always_comb
  begin
    logic a_rise;
    logic a_tog;
    a_rise = EVENT_A && !eva_prev_q;
    a_tog  = EVENT_A != eva_prev_q;
    cnt_step = PRESCALE_TICK;
    dir_d = dir_q;
    if (event_control_q[`TEC_EV_A_EN])                         // R11
    begin
      unique case (eva)
        TEC_EVA_RISE:   cnt_step = a_rise;               // R6
        TEC_EVA_TOGGLE: cnt_step = a_tog;                // R6
        TEC_EVA_HIGH:   cnt_step = PRESCALE_TICK && EVENT_A; // R6
        TEC_EVA_DIRECTION_BY_EVENT: cnt_step = PRESCALE_TICK;        // R7
        default:        cnt_step = 1'b0;
      endcase
      if (eva == TEC_EVA_DIRECTION_BY_EVENT && cnt_step)
        dir_d = EVENT_A;                                 // R7
    end
    if (event_control_q[`TEC_EV_B_EN] && evb == TEC_EVB_DIRECTION_BY_EVENT && cnt_step) // R10
      dir_d = EVENT_B;                                   // R8
    if (!event_control_q[`TEC_EV_B_EN])
      evb_rst_d = 1'b0;
    else
    begin
      unique case (evb)
        TEC_EVB_RST_RISE: evb_rst_d = EVENT_B && !evb_prev_q;   // R9
        TEC_EVB_RST_TOG:  evb_rst_d = EVENT_B != evb_prev_q;    // R9
        TEC_EVB_RST_HIGH: evb_rst_d = EVENT_B;                  // R9
        default:          evb_rst_d = 1'b0;
      endcase
    end
  end

  // Update and wrap conditions per waveform mode
  always_comb
  begin
    upd_evt  = 1'b0;
    wrap_evt = 1'b0;
    if (cnt_step)
    begin
      unique case (tec_wg_t'(mode_q))                    // R19
        TEC_WG_NORMAL, TEC_WG_FREQ:
        begin
          upd_evt  = at_top && !dir_d;
          wrap_evt = at_top && !dir_d;
        end
        TEC_WG_SINGLE:
        begin
          upd_evt  = at_bot;
          wrap_evt = at_bot;
        end
        TEC_WG_DSTOP:
        begin
          upd_evt  = at_bot;
          wrap_evt = at_top;
        end
        TEC_WG_DSBOTH:
        begin
          upd_evt  = at_bot;
          wrap_evt = at_top || at_bot;
        end
        TEC_WG_DSBOT:
        begin
          upd_evt  = at_bot;
          wrap_evt = at_bot;
        end
        default:
        begin
          upd_evt  = 1'b0;
          wrap_evt = 1'b0;
        end
      endcase
    end
  end

  assign transfer = (upd_evt && !lock_q) || force_upd;   // R18

  for (genvar c = 0; c < 3; c++)
  begin : g_cmp
    assign cmp_hit[c] = (cnt_q == cmp_q[c]);
  end

  // Register file and control state
  always_comb
  begin
    bv_d     = bv_q;
    event_control_d = event_control_q;
    inten_d  = inten_q;
    flags_d  = flags_q;
    mode_d   = mode_q;
    lock_d   = lock_q;
    rdata_d  = '0;
    if (transfer)
      bv_d = '0;                                         // R1 R2
    if (REG_WR)
    begin
      if (hit(REG_ADDR, `TEC_OFF_BV_CLEAR))
        bv_d = bv_d & ~REG_WDATA[3:0];                   // R17
      if (hit(REG_ADDR, `TEC_OFF_EVENT_CONTROL))
        event_control_d = REG_WDATA[7:0];                       // R5
      if (hit(REG_ADDR, `TEC_OFF_INT_EN))
        inten_d = REG_WDATA[7:0] & 8'h71;                // R12
      if (hit(REG_ADDR, `TEC_OFF_INT_FLAGS))
        flags_d = flags_d & ~(REG_WDATA[7:0] & 8'h71);   // R14 R15
      if (hit(REG_ADDR, `TEC_OFF_CTRL))
      begin
        mode_d = REG_WDATA[`TEC_CTRL_MODE_LSB +: 3];
        lock_d = REG_WDATA[`TEC_CTRL_LOCK];
      end
    end
    // Sets come last so they win over a clear in the same cycle
    if (REG_WR && hit(REG_ADDR, `TEC_OFF_BV_SET))
      bv_d = bv_d | REG_WDATA[3:0];                      // R4
    if (wr_buf)
      bv_d[REG_WDATA[W-1 -: 2]] = 1'b1;                  // R1 R2 R3
    flags_d[`TEC_INT_CHAN0 +: 3] = flags_d[`TEC_INT_CHAN0 +: 3] | cmp_hit; // R13 R16
    if (wrap_evt)
      flags_d[`TEC_INT_WRAP] = 1'b1;                     // R15
    if (REG_RD)
    begin
      if (hit(REG_ADDR, `TEC_OFF_BV_CLEAR) || hit(REG_ADDR, `TEC_OFF_BV_SET))
        rdata_d = W'(bv_q);
      else if (hit(REG_ADDR, `TEC_OFF_EVENT_CONTROL))
        rdata_d = W'(event_control_q);
      else if (hit(REG_ADDR, `TEC_OFF_INT_EN))
        rdata_d = W'(inten_q);
      else if (hit(REG_ADDR, `TEC_OFF_INT_FLAGS))
        rdata_d = W'(flags_q);
      else if (hit(REG_ADDR, `TEC_OFF_CTRL))
        rdata_d = W'({dir_q, lock_q, mode_q});
    end
  end

  // Counter
  always_comb
  begin
    cnt_d = cnt_q;
    if (evb_rst_q)
      cnt_d = '0;                                        // R9
    else if (cnt_step)
    begin
      // Step takes the direction latched at this same count
      if (!dir_d && at_top && mode_q < 3'h5)
        cnt_d = '0;
      else
        cnt_d = dir_d ? cnt_q - 1'b1 : cnt_q + 1'b1;
    end
  end

  // Working copies, tracked locally for the compare and top logic
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
    begin
      for (int i = 0; i < 3; i++)
        cmp_q[i] <= `TEC_RST_COMPARE;
      per_q  <= `TEC_RST_PERIOD;
      scan_q <= '0;
    end
    else if (CLK_EN)
    begin
      scan_q <= scan_q + 2'd1;
      // Read-out is registered once, so data trail the selector by one step
      unique case (scan_q)
        2'd1: per_q    <= scan_data;
        2'd2: cmp_q[0] <= scan_data;
        2'd3: cmp_q[1] <= scan_data;
        2'd0: cmp_q[2] <= scan_data;
      endcase
    end
  end

  tec_buffers #(.W(W)) u_buf (
    .clk      (CORE_CLK),
    .rst_n    (RESET_N),
    .ce       (CLK_EN),
    .wr_sel   (REG_WDATA[W-1 -: 2]),
    .wr_en    (wr_buf),
    .wr_data  ({2'b00, REG_WDATA[W-3:0]}),
    .transfer (transfer),
    .rd_sel   (scan_q),
    .rd_data  (scan_data)
  );

  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
    begin
      bv_q       <= '0;
      event_control_q   <= `TEC_RST_BYTE;
      inten_q    <= `TEC_RST_BYTE;
      flags_q    <= `TEC_RST_BYTE;
      mode_q     <= '0;
      lock_q     <= 1'b0;
      cnt_q      <= '0;
      dir_q      <= 1'b0;
      evb_rst_q  <= 1'b0;
      eva_prev_q <= 1'b0;
      evb_prev_q <= 1'b0;
      rdata_q    <= '0;
      irq_q      <= 1'b0;
    end
    else if (CLK_EN)
    begin
      bv_q       <= bv_d;
      event_control_q   <= event_control_d;
      inten_q    <= inten_d;
      flags_q    <= flags_d;
      mode_q     <= mode_d;
      lock_q     <= lock_d;
      cnt_q      <= cnt_d;
      dir_q      <= dir_d;
      evb_rst_q  <= evb_rst_d;
      eva_prev_q <= EVENT_A;
      evb_prev_q <= EVENT_B;
      rdata_q    <= rdata_d;
      irq_q      <= |(flags_d & inten_d);               // R20
    end
  end

  assign REG_RDATA   = rdata_q;
  assign COUNT_VALUE = cnt_q;
  assign COUNT_DOWN  = dir_q;
  assign IRQ         = irq_q;

  a_flag_sticky: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // R14
    CLK_EN && flags_q[4] && !(REG_WR && REG_ADDR == 8'h0b && REG_WDATA[4]) |=> flags_q[4])
    else $error("channel flag cleared without write");
  a_match_sets: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // R13
    CLK_EN && cmp_hit[0] |=> flags_q[4])
    else $error("compare match did not set flag");
  a_bv_set_alias: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // R4
    CLK_EN && REG_WR && REG_ADDR == 8'h07 && REG_WDATA[1] |=> bv_q[1])
    else $error("set alias did not set valid bit");
  a_bv_update: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // R1
    CLK_EN && transfer && !REG_WR |=> bv_q == 4'h0)
    else $error("update did not clear valid bits");
  a_irq_follows: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // R20
    CLK_EN ##1 CLK_EN |-> IRQ == |($past(flags_d) & $past(inten_d)))
    else $error("interrupt request mismatch");
  a_enable_mask: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // R12
    (inten_q & 8'h8e) == 8'h00)
    else $error("reserved enable bit set");
  a_evb_off: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // R10
    !event_control_q[4] |-> !evb_rst_d)
    else $error("event B acted while disabled");
  a_lock_blocks: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // R18
    lock_q && !force_upd |-> !transfer)
    else $error("locked update transferred");
endmodule

// ===== tb/tec_event_src.sv
// Event system model driving the two counter event inputs
module tec_event_src
(
  input  wire logic clk,   // Core clock
  output logic      ev_a,  // Event line A
  output logic      ev_b   // Event line B
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    ev_a = 1'b0;
    ev_b = 1'b0;
  end

  // Lines move just after an edge so the core samples a settled level
  task automatic set_line(input bit sel, input bit v);
    @(posedge clk);
    if (sel)
      ev_b <= v;
    else
      ev_a <= v;
  endtask

  // Hold sets the pulse width; slow pulses show edges are not lost
  task automatic pulse(input bit sel, input int n, input int hold);
    repeat (n)
    begin
      set_line(sel, 1'b1);
      repeat (hold) @(posedge clk);
      set_line(sel, 1'b0);
      repeat (hold) @(posedge clk);
    end
  endtask
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the timer control slice
`include "tec_regs.svh"
module testbench;
  import tec_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        rst_n;
  logic        clk_en;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic        tick;
  logic [15:0] rdata;
  logic [15:0] cnt;
  logic        down;
  logic        irq;
  logic        ev_a;
  logic        ev_b;
  int          mismatches = 0;
  int          check_count = 0;

  always #2.5 clk = ~clk;

  tec_core dut (.CORE_CLK(clk), .RESET_N(rst_n), .CLK_EN(clk_en), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .PRESCALE_TICK(tick), .EVENT_A(ev_a), .EVENT_B(ev_b), .COUNT_VALUE(cnt),
    .COUNT_DOWN(down), .IRQ(irq));

  tec_event_src evs (.clk(clk), .ev_a(ev_a), .ev_b(ev_b));

  task automatic end_of_test;
    $display("Checks made %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(nm, exp, rdata);
  endtask

  task automatic ticks(input int n);
    @(posedge clk);
    tick <= 1'b1;
    repeat (n) @(posedge clk);
    tick <= 1'b0;
  endtask

  // Settle time covers edge detection and the late restart
  task automatic cnt_chk(input logic [15:0] exp, input logic dn);
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("count", exp, cnt);
    chk("direction", {15'h0000, dn}, {15'h0000, down});
  endtask

  task automatic wait_irq(input logic exp);
    int n;
    n = 0;
    while (irq !== exp && n < 10)
    begin
      @(negedge clk);
      n++;
    end
    chk("irq", {15'h0000, exp}, {15'h0000, irq});
    if (n >= 10)
      end_of_test();
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_of_test();
  end

  initial
  begin
    logic [13:0] vals [4];
    vals = '{14'd20, 14'd2, 14'd3, 14'd4};
    rst_n = 1'b0;
    clk_en = 1'b1;
    addr = 8'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    tick = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk("event_control", `TEC_OFF_EVENT_CONTROL, 16'h0000);
    rd_chk("enables", `TEC_OFF_INT_EN, 16'h0000);
    rd_chk("valid", `TEC_OFF_BV_SET, 16'h0000);
    wr_reg(`TEC_OFF_EVENT_CONTROL, 16'h00ff);
    rd_chk("event_control", `TEC_OFF_EVENT_CONTROL, 16'h00ff);
    wr_reg(`TEC_OFF_INT_EN, 16'h00ff);
    rd_chk("enables", `TEC_OFF_INT_EN, 16'h0071);
    wr_reg(`TEC_OFF_INT_EN, 16'h0000);
    wr_reg(`TEC_OFF_EVENT_CONTROL, 16'h0000);
    wr_reg(`TEC_OFF_CTRL, 16'h0008);
    for (int s = 0; s < 4; s++)
    begin
      wr_reg(`TEC_OFF_BUF_WRITE, {2'(s), vals[s]});
      rd_chk("valid", `TEC_OFF_BV_SET, 16'((2 << s) - 1));
    end
    // Forced update must go through although the lock is held
    wr_reg(`TEC_OFF_CTRL, 16'h0018);
    rd_chk("valid", `TEC_OFF_BV_SET, 16'h0000);
    wr_reg(`TEC_OFF_BV_SET, 16'h0005);
    rd_chk("valid", `TEC_OFF_BV_SET, 16'h0005);
    wr_reg(`TEC_OFF_BV_SET, 16'h000a);
    rd_chk("valid", `TEC_OFF_BV_SET, 16'h000f);
    wr_reg(`TEC_OFF_BV_CLEAR, 16'h0003);
    rd_chk("valid", `TEC_OFF_BV_CLEAR, 16'h000c);
    wr_reg(`TEC_OFF_CTRL, 16'h0000);
    repeat (8) @(posedge clk);
    wr_reg(`TEC_OFF_INT_FLAGS, 16'h0071);
    rd_chk("flags", `TEC_OFF_INT_FLAGS, 16'h0000);
    ticks(30);
    cnt_chk(16'd9, 1'b0);
    rd_chk("valid", `TEC_OFF_BV_SET, 16'h0000);
    rd_chk("flags", `TEC_OFF_INT_FLAGS, 16'h0071);
    wait_irq(1'b0);
    repeat (20) @(posedge clk);
    rd_chk("flags", `TEC_OFF_INT_FLAGS, 16'h0071);
    wr_reg(`TEC_OFF_INT_EN, 16'h0010);
    wait_irq(1'b1);
    wr_reg(`TEC_OFF_INT_FLAGS, 16'h0010);
    rd_chk("flags", `TEC_OFF_INT_FLAGS, 16'h0061);
    wait_irq(1'b0);
    wr_reg(`TEC_OFF_INT_EN, 16'h0001);
    wait_irq(1'b1);
    wr_reg(`TEC_OFF_INT_FLAGS, 16'h0001);
    rd_chk("flags", `TEC_OFF_INT_FLAGS, 16'h0060);
    wait_irq(1'b0);
    wr_reg(`TEC_OFF_INT_EN, 16'h0000);
    wr_reg(`TEC_OFF_EVENT_CONTROL, 16'h0080);
    evs.pulse(1'b1, 1, 2);
    cnt_chk(16'd9, 1'b0);
    wr_reg(`TEC_OFF_EVENT_CONTROL, 16'h0090);
    evs.pulse(1'b0, 3, 2);
    cnt_chk(16'd9, 1'b0);
    wr_reg(`TEC_OFF_EVENT_CONTROL, 16'h0091);
    evs.set_line(1'b1, 1'b1);
    cnt_chk(16'd0, 1'b0);
    evs.pulse(1'b0, 2, 2);
    evs.pulse(1'b0, 1, 6);
    cnt_chk(16'd3, 1'b0);
    evs.set_line(1'b1, 1'b0);
    cnt_chk(16'd3, 1'b0);
    wr_reg(`TEC_OFF_EVENT_CONTROL, 16'h00b3);
    evs.set_line(1'b1, 1'b1);
    cnt_chk(16'd0, 1'b0);
    evs.pulse(1'b0, 2, 2);
    cnt_chk(16'd4, 1'b0);
    evs.set_line(1'b1, 1'b0);
    cnt_chk(16'd0, 1'b0);
    wr_reg(`TEC_OFF_EVENT_CONTROL, 16'h00d5);
    evs.set_line(1'b0, 1'b1);
    ticks(5);
    cnt_chk(16'd5, 1'b0);
    evs.set_line(1'b0, 1'b0);
    ticks(5);
    cnt_chk(16'd5, 1'b0);
    evs.set_line(1'b0, 1'b1);
    evs.set_line(1'b1, 1'b1);
    ticks(3);
    cnt_chk(16'd0, 1'b0);
    evs.set_line(1'b1, 1'b0);
    evs.set_line(1'b0, 1'b0);
    wr_reg(`TEC_OFF_EVENT_CONTROL, 16'h0007);
    ticks(5);
    cnt_chk(16'd5, 1'b0);
    evs.set_line(1'b0, 1'b1);
    ticks(3);
    cnt_chk(16'd2, 1'b1);
    evs.set_line(1'b0, 1'b0);
    wr_reg(`TEC_OFF_EVENT_CONTROL, 16'h0070);
    ticks(2);
    cnt_chk(16'd4, 1'b0);
    evs.set_line(1'b1, 1'b1);
    ticks(3);
    cnt_chk(16'd1, 1'b1);
    wr_reg(`TEC_OFF_EVENT_CONTROL, 16'h0000);
    wr_reg(`TEC_OFF_INT_FLAGS, 16'h0071);
    wr_reg(`TEC_OFF_CTRL, 16'h0003);
    ticks(2);
    cnt_chk(16'hffff, 1'b1);
    rd_chk("control", `TEC_OFF_CTRL, 16'h0013);
    rd_chk("flags", `TEC_OFF_INT_FLAGS, 16'h0001);
    end_of_test();
  end
endmodule
